// >>> mce_pkg.sv
`default_nettype none
package mce_pkg;
	localparam logic [11:0] ADDR_CAPTURE_PIN_1_CTRL = 12'h000;
	localparam logic [11:0] ADDR_CAPTURE_PIN_2_CTRL = 12'h004;
	localparam logic [11:0] ADDR_CAPTURE_PIN_3_CTRL = 12'h008;
	localparam logic [11:0] ADDR_ENC_CTRL = 12'h00C;
	localparam logic [11:0] ADDR_BUF1 = 12'h010;
	localparam logic [11:0] ADDR_BUF2 = 12'h014;
	localparam logic [11:0] ADDR_BUF3 = 12'h018;
	localparam logic [11:0] ADDR_FLAGS = 12'h01C;
	localparam logic [11:0] ADDR_MISC = 12'h020;
	localparam int CAP_REN_BIT = 6;
	localparam int ENC_VELDIS_BIT = 7;
	localparam int ENC_ERR_BIT = 6;
	localparam int ENC_DIR_BIT = 5;
	localparam int MISC_TRIG_RST_DIS_BIT = 0;
	localparam int MISC_POS_IE_BIT = 1;
	localparam logic [7:0] CAP_CTRL_RST = 8'h00;
	localparam logic [7:0] ENC_CTRL_RST = 8'h00;
	localparam logic [3:0] CM_OFF = 4'h0;
	localparam logic [3:0] CM_FALL = 4'h1;
	localparam logic [3:0] CM_RISE = 4'h2;
	localparam logic [3:0] CM_RISE4 = 4'h3;
	localparam logic [3:0] CM_RISE16 = 4'h4;
	localparam logic [3:0] CM_PERIOD = 4'h5;
	localparam logic [3:0] CM_PW_FR = 4'h6;
	localparam logic [3:0] CM_PW_RF = 4'h7;
	localparam logic [3:0] CM_STATE = 4'h8;
	localparam logic [3:0] CM_TRIG_F = 4'hE;
	localparam logic [3:0] CM_TRIG_R = 4'hF;
	localparam logic [2:0] EM_OFF = 3'h0;
	localparam logic [2:0] EM_X2_IDX = 3'h1;
	localparam logic [2:0] EM_X2_MAT = 3'h2;
	localparam logic [2:0] EM_X4_IDX = 3'h5;
	localparam logic [2:0] EM_X4_MAT = 3'h6;
	localparam logic [5:0] PRESC_4_MAX = 6'h03;
	localparam logic [5:0] PRESC_16_MAX = 6'h0F;
	localparam logic [5:0] PRESC_64_MAX = 6'h3F;
	typedef struct packed {
		logic [11:0] addr;
		logic write;
		logic [31:0] wdata;
	} mce_apb_req_t;
	typedef struct packed {
		logic capture_pin_3;
		logic capture_pin_2;
		logic capture_pin_1;
	} mce_pins_t;
endpackage
`default_nettype wire

// >>> mce_ctrl.sv
// Design decisions made here: register access over APB and the register addresses.
`default_nettype none
// Overview of operation
// - state-change mode captures both edges
// - three state-change channels detect hall transitions
// - first edge after mode select captures if it qualifies
// - every active edge captures; reset if enabled
// - mode switching never touches time base
// - capture reset gated by reset enable
// - pulse-width always resets at initiating edge
// - per-channel flag on capture events
// - channel 1 trigger mode, no flag
// - 1110 falling, 1111 rising trigger
// - trigger resets time base unless disabled
// - edges sampled once per cycle, late next
// - encoder mode wins over capture
// - encoder remaps the three buffers
// - 16-bit up/down count, x2 or x4
// - edge detect, index sample, direction, velocity
// - count reset by match or index, flag
// - direction bit, change sets flag
// - error on wrap in index mode, sw clear
// - velocity postscaler 1, 4, 16, 64
// - edge modes with per-channel prescaler
// - velocity active only when enabled, encoder on
// - encoder mode code decode
module mce_ctrl
	import mce_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// pins, asynchronous
	input wire logic i_capture_pin_1,
	input wire logic i_capture_pin_2,
	input wire logic i_capture_pin_3,
	// time base
	input wire logic [15:0] i_timebase,
	output logic o_timebase_reset,
	output logic o_special_trigger,
	output logic o_velocity_pulse
);
	mce_apb_req_t req;
	mce_pins_t s1_r, s2_r, prev_r;
	logic [7:0] cap_ctrl_r [3];
	logic [7:0] enc_ctrl_r;
	logic [1:0] misc_r;
	logic [15:0] buf_r [3];
	logic [15:0] pos_count_r, pos_limit_r, vel_cnt_r;
	logic [2:0] flag_r;
	logic [3:0] presc_r [3];
	logic [2:0] armed_r;
	logic [5:0] vdiv_r;
	logic idx_prev_r;
	logic wr, rd;
	logic [2:0] pin_now, pin_old, rise, fall;
	logic [2:0] cap_ev, rst_ev, cap_flag;
	logic [3:0] mode [3];
	logic [2:0] em;
	logic enc_on, enc_idx_mode, trig_ev;
	logic pa, pb, pa_old, pb_old, idx, a_edge, b_edge, cnt_ev, up;
	logic idx_ev, match_ev, wrap_ev, pos_rst_ev, dir_chg, vel_ev;
	logic [5:0] vmax;

	assign req = '{addr: i_paddr, write: i_pwrite, wdata: i_pwdata};
	assign wr = i_psel && i_penable && req.write;
	assign rd = i_psel && i_penable && !req.write;
	assign o_pready = 1'b1;
	assign o_pslverr = 1'b0;

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s1_r <= '0;
			s2_r <= '0;
			prev_r <= '0;
		end
		else
		begin
			s1_r <= '{i_capture_pin_3, i_capture_pin_2, i_capture_pin_1};
			s2_r <= s1_r;
			prev_r <= s2_r;
		end
	end
	assign pin_now = s2_r;
	assign pin_old = prev_r;
	assign rise = pin_now & ~pin_old;
	assign fall = ~pin_now & pin_old;

	assign em = enc_ctrl_r[4:2];
	assign enc_on = (em == EM_X2_IDX) || (em == EM_X2_MAT) ||
		(em == EM_X4_IDX) || (em == EM_X4_MAT);
	assign enc_idx_mode = (em == EM_X2_IDX) || (em == EM_X4_IDX);
	assign pa = pin_now[0];
	assign pb = pin_now[1];
	assign idx = pin_now[2];
	assign pa_old = pin_old[0];
	assign pb_old = pin_old[1];

	// capture event decode, one channel per generate pass
	generate
		for (genvar c = 0; c < 3; c++)
		begin : g_ch
			logic [3:0] m;
			logic presc_hit;
			assign m = enc_on ? CM_OFF : cap_ctrl_r[c][3:0];
			assign mode[c] = m;
			assign presc_hit = (m == CM_RISE4) ?
				(presc_r[c] == PRESC_4_MAX[3:0]) :
				(presc_r[c] == PRESC_16_MAX[3:0]);
			always_comb
			begin
				cap_ev[c] = 1'b0;
				rst_ev[c] = 1'b0;
				case (m)
					CM_FALL: cap_ev[c] = fall[c];
					CM_RISE, CM_PERIOD: cap_ev[c] = rise[c];
					CM_RISE4, CM_RISE16:
						cap_ev[c] = rise[c] && (presc_hit || !armed_r[c]);
					// reset at start, capture at end
					CM_PW_FR:
					begin
						rst_ev[c] = fall[c];
						cap_ev[c] = rise[c] || (fall[c] && !armed_r[c]);
					end
					CM_PW_RF:
					begin
						rst_ev[c] = rise[c];
						cap_ev[c] = fall[c] || (rise[c] && !armed_r[c]);
					end
					CM_STATE: cap_ev[c] = rise[c] | fall[c];
					default: cap_ev[c] = 1'b0;
				endcase
				if (m != CM_PW_FR && m != CM_PW_RF)
					rst_ev[c] = cap_ev[c] && cap_ctrl_r[c][CAP_REN_BIT];
			end
			assign cap_flag[c] = cap_ev[c];
			always_ff @(posedge i_core_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					presc_r[c] <= '0;
					armed_r[c] <= 1'b0;
				end
				else if (m == CM_OFF || wr && req.addr == 12'(c * 4))
				begin
					// prescaler cleared only when disabled
					if (m == CM_OFF)
						presc_r[c] <= '0;
					armed_r[c] <= 1'b0;
				end
				else
				begin
					if ((m == CM_RISE4 || m == CM_RISE16) && rise[c])
						presc_r[c] <= presc_hit ? 4'h0 : presc_r[c] + 4'h1;
					if (rise[c] || fall[c])
						armed_r[c] <= 1'b1;
				end
			end
		end
	endgenerate

	assign trig_ev = !enc_on &&
		((cap_ctrl_r[0][3:0] == CM_TRIG_F && fall[0]) ||
		(cap_ctrl_r[0][3:0] == CM_TRIG_R && rise[0]));

	assign a_edge = pa ^ pa_old;
	assign b_edge = pb ^ pb_old;
	assign cnt_ev = enc_on && (a_edge ||
		(b_edge && (em == EM_X4_IDX || em == EM_X4_MAT)));
	// forward when a leads b
	assign up = a_edge ? (pa ^ pb) : !(pa ^ pb);
	assign dir_chg = cnt_ev && (up != enc_ctrl_r[ENC_DIR_BIT]);
	assign idx_ev = enc_idx_mode && idx && !idx_prev_r;
	assign match_ev = cnt_ev && !enc_idx_mode &&
		(up ? pos_count_r == pos_limit_r : pos_count_r == 16'h0000);
	assign wrap_ev = cnt_ev && enc_idx_mode &&
		(up ? pos_count_r == 16'hFFFF : pos_count_r == 16'h0000);
	assign pos_rst_ev = (idx_ev || match_ev) && misc_r[MISC_POS_IE_BIT];

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pos_count_r <= '0;
			idx_prev_r <= 1'b0;
		end
		else
		begin
			idx_prev_r <= idx;
			if (wr && req.addr == ADDR_BUF2)
				pos_count_r <= req.wdata[15:0];
			else if (idx_ev)
				pos_count_r <= 16'h0000;
			else if (match_ev)
				pos_count_r <= up ? 16'h0000 : pos_limit_r;
			else if (cnt_ev)
				pos_count_r <= up ? pos_count_r + 16'h0001 :
					pos_count_r - 16'h0001;
		end
	end

	assign vel_ev = cnt_ev && !enc_ctrl_r[ENC_VELDIS_BIT];
	always_comb
	begin
		case (enc_ctrl_r[1:0])
			2'b00: vmax = 6'h00;
			2'b01: vmax = PRESC_4_MAX;
			2'b10: vmax = PRESC_16_MAX;
			default: vmax = PRESC_64_MAX;
		endcase
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			vdiv_r <= '0;
			o_velocity_pulse <= 1'b0;
		end
		else
		begin
			o_velocity_pulse <= 1'b0;
			if (vel_ev)
			begin
				vdiv_r <= (vdiv_r >= vmax) ? 6'h00 : vdiv_r + 6'h01;
				o_velocity_pulse <= (vdiv_r >= vmax);
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_timebase_reset <= 1'b0;
			o_special_trigger <= 1'b0;
		end
		else
		begin
			o_special_trigger <= trig_ev;
			o_timebase_reset <= (|rst_ev) ||
				(trig_ev && !misc_r[MISC_TRIG_RST_DIS_BIT]);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			buf_r[0] <= '0;
			buf_r[1] <= '0;
			buf_r[2] <= '0;
			pos_limit_r <= '0;
			vel_cnt_r <= '0;
		end
		else
		begin
			for (int c = 0; c < 3; c++)
				if (cap_ev[c])
					buf_r[c] <= i_timebase;
			if (vel_ev)
				vel_cnt_r <= i_timebase;
			if (wr && req.addr == ADDR_BUF3)
				pos_limit_r <= req.wdata[15:0];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			flag_r <= '0;
			enc_ctrl_r <= ENC_CTRL_RST;
			cap_ctrl_r[0] <= CAP_CTRL_RST;
			cap_ctrl_r[1] <= CAP_CTRL_RST;
			cap_ctrl_r[2] <= CAP_CTRL_RST;
			misc_r <= '0;
		end
		else
		begin
			if (wr && req.addr == ADDR_FLAGS)
				flag_r <= flag_r & ~req.wdata[2:0];
			if (cap_flag[0] || (enc_on && vel_ev))
				flag_r[0] <= 1'b1;
			if (cap_flag[1] || pos_rst_ev)
				flag_r[1] <= 1'b1;
			if (cap_flag[2] || dir_chg)
				flag_r[2] <= 1'b1;
			for (int c = 0; c < 3; c++)
				if (wr && req.addr == 12'(c * 4))
					cap_ctrl_r[c] <= {1'b0, req.wdata[6], 2'b00,
						req.wdata[3:0]};
			if (wr && req.addr == ADDR_MISC)
				misc_r <= req.wdata[1:0];
			if (wr && req.addr == ADDR_ENC_CTRL)
			begin
				enc_ctrl_r[7] <= req.wdata[7];
				enc_ctrl_r[4:0] <= req.wdata[4:0];
				if (!req.wdata[ENC_ERR_BIT])
					enc_ctrl_r[ENC_ERR_BIT] <= 1'b0;
			end
			if (wrap_ev)
				enc_ctrl_r[ENC_ERR_BIT] <= 1'b1;
			if (cnt_ev)
				enc_ctrl_r[ENC_DIR_BIT] <= up;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_prdata <= '0;
		else if (i_psel && !i_penable && !req.write)
		begin
			case (req.addr)
				ADDR_CAPTURE_PIN_1_CTRL: o_prdata <= {24'h0, cap_ctrl_r[0]};
				ADDR_CAPTURE_PIN_2_CTRL: o_prdata <= {24'h0, cap_ctrl_r[1]};
				ADDR_CAPTURE_PIN_3_CTRL: o_prdata <= {24'h0, cap_ctrl_r[2]};
				ADDR_ENC_CTRL: o_prdata <= {24'h0, enc_ctrl_r};
				ADDR_BUF1: o_prdata <= {16'h0,
					enc_on ? vel_cnt_r : buf_r[0]};
				ADDR_BUF2: o_prdata <= {16'h0,
					enc_on ? pos_count_r : buf_r[1]};
				ADDR_BUF3: o_prdata <= {16'h0,
					enc_on ? pos_limit_r : buf_r[2]};
				ADDR_FLAGS: o_prdata <= {29'h0, flag_r};
				ADDR_MISC: o_prdata <= {30'h0, misc_r};
				default: o_prdata <= '0;
			endcase
		end
	end

	property p_err_idx;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		wrap_ev |=> enc_ctrl_r[ENC_ERR_BIT];
	endproperty
	a_err_idx: assert property (p_err_idx)
		else $error("position error not set");
	property p_trig;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		trig_ev |=> o_special_trigger &&
			(!flag_r[0] || $past(flag_r[0]));
	endproperty
	a_trig: assert property (p_trig)
		else $error("trigger not issued");
	property p_buf;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		cap_ev[1] |=> buf_r[1] == $past(i_timebase);
	endproperty
	a_buf: assert property (p_buf)
		else $error("buffer not stamped");
	property p_excl;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		enc_on |-> cap_ev == 3'b000 && !trig_ev;
	endproperty
	a_excl: assert property (p_excl)
		else $error("capture active in encoder mode");
	property p_pw_rst;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(mode[0] == CM_PW_RF && rise[0]) |=> o_timebase_reset;
	endproperty
	a_pw_rst: assert property (p_pw_rst)
		else $error("pulse width did not reset time base");
	property p_dir;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		dir_chg |=> flag_r[2] && enc_ctrl_r[ENC_DIR_BIT] == $past(up);
	endproperty
	a_dir: assert property (p_dir)
		else $error("direction change not flagged");
	property p_state;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(mode[0] == CM_STATE && (rise[0] || fall[0])) |=> flag_r[0];
	endproperty
	a_state: assert property (p_state)
		else $error("state change not captured");
	property p_norst;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(rst_ev == 3'b000 && !trig_ev) |=> !o_timebase_reset;
	endproperty
	a_norst: assert property (p_norst)
		else $error("spurious time base reset");
endmodule
`default_nettype wire

// >>> mce_pins_model.sv
`default_nettype none
module mce_pins_model
	import mce_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// commands from the bench
	input wire logic i_step,
	input wire logic [1:0] i_kind,
	input wire logic i_reverse,
	input wire logic i_index,
	// sensor pins
	output mce_pins_t o_pins
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] ph_r;
	logic tog_r;
	logic [2:0] lim;
	logic [2:0] hall;
	logic [1:0] quad;
	// six valid hall states, four quadrature states
	assign lim = (i_kind == 2'd0) ? 3'd5 : 3'd3;
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ph_r <= 3'h0;
			tog_r <= 1'b0;
		end
		else if (i_step)
		begin
			tog_r <= ~tog_r;
			if (i_reverse)
				ph_r <= (ph_r == 3'h0) ? lim : ph_r - 3'h1;
			else
				ph_r <= (ph_r >= lim) ? 3'h0 : ph_r + 3'h1;
		end
	end
	always_comb
	begin
		case (ph_r)
			3'h0: hall = 3'b001;
			3'h1: hall = 3'b011;
			3'h2: hall = 3'b010;
			3'h3: hall = 3'b110;
			3'h4: hall = 3'b100;
			default: hall = 3'b101;
		endcase
	end
	// gray order: only one phase moves per step, a leads b going forward
	assign quad = {ph_r[1], ph_r[1] ^ ph_r[0]};
	assign o_pins = (i_kind == 2'd2) ? mce_pins_t'({2'b00, tog_r}) :
		(i_kind == 2'd1) ? mce_pins_t'({i_index, quad}) : mce_pins_t'(hall);
endmodule
`default_nettype wire

// >>> tb.sv
`default_nettype none
module tb
	import mce_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, psel, penable, pwrite, stp, rev, idx_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, tb_rst, trig, vel;
	logic [15:0] tbase;
	logic [1:0] kind;
	mce_pins_t pins;
	int fail_count = 0;
	int n_compared = 0;
	int nrst = 0, ntrig = 0, nvel = 0;
	int r0, r1, p0;
	logic [1:0] chg [6] = '{2'd1, 2'd0, 2'd2, 2'd1, 2'd0, 2'd2};
	logic [3:0] tcode [2] = '{CM_TRIG_F, CM_TRIG_R};
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// pulses are one cycle wide, so counting edges counts events
	always @(posedge clk)
	begin
		if (tb_rst === 1'b1)
			nrst <= nrst + 1;
		if (trig === 1'b1)
			ntrig <= ntrig + 1;
		if (vel === 1'b1)
			nvel <= nvel + 1;
	end
	mce_pins_model u_far (
		.i_core_clk(clk),
		.i_rst_n(rst_n),
		.i_step(stp),
		.i_kind(kind),
		.i_reverse(rev),
		.i_index(idx_in),
		.o_pins(pins)
	);
	mce_ctrl u_dut (
		.i_core_clk(clk),
		.i_rst_n(rst_n),
		.i_psel(psel),
		.i_penable(penable),
		.i_pwrite(pwrite),
		.i_paddr(paddr),
		.i_pwdata(pwdata),
		.o_prdata(prdata),
		.o_pready(pready),
		.o_pslverr(pslverr),
		.i_capture_pin_1(pins.capture_pin_1),
		.i_capture_pin_2(pins.capture_pin_2),
		.i_capture_pin_3(pins.capture_pin_3),
		.i_timebase(tbase),
		.o_timebase_reset(tb_rst),
		.o_special_trigger(trig),
		.o_velocity_pulse(vel)
	);
	task automatic tally_and_finish();
		$display("compared %0d wrong %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: %h not %h", $time, got, exp);
			fail_count++;
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		if (pslverr !== 1'b0)
		begin
			$display("wrong value at %0t: slave error", $time);
			fail_count++;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			$display("wrong value at %0t: no ready", $time);
			fail_count++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	task automatic enc(input logic [7:0] v);
		wr(ADDR_ENC_CTRL, {24'h0, v});
	endtask
	// about three cycles from pin to result, six leaves margin
	task automatic step(input int n);
		repeat (n)
		begin
			@(posedge clk);
			stp <= 1'b1;
			@(posedge clk);
			stp <= 1'b0;
			repeat (6) @(posedge clk);
		end
	endtask
	initial
	begin
		rst_n = 1'b0;
		{psel, penable, pwrite, stp, rev, idx_in} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		tbase = 16'h0000;
		kind = 2'd0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 3; i++)
			rd(ADDR_CAPTURE_PIN_1_CTRL + 12'(4 * i), 32'(CAP_CTRL_RST), 32'hFF);
		rd(ADDR_ENC_CTRL, 32'(ENC_CTRL_RST), 32'hFF);
		wr(12'h030, 32'hFFFFFFFF);
		rd(12'h030, 32'h0, 32'hFFFFFFFF);
		for (int i = 0; i < 3; i++)
			wr(ADDR_CAPTURE_PIN_1_CTRL + 12'(4 * i), 32'(CM_STATE));
		r0 = nrst;
		for (int i = 0; i < 6; i++)
		begin
			tbase <= 16'h1000 + 16'(i);
			wr(ADDR_FLAGS, 32'h7);
			step(1);
			rd(ADDR_FLAGS, 32'h1 << chg[i], 32'h7);
			rd(ADDR_BUF1 + 12'(4 * chg[i]), 32'h1000 + i, 32'hFFFF);
		end
		chk(32'(nrst), 32'(r0));
		wr(ADDR_CAPTURE_PIN_1_CTRL, 32'(CM_STATE) | 32'h40);
		// a reset pulse from the write would show a few edges later
		repeat (3) @(posedge clk);
		chk(32'(nrst), 32'(r0));
		step(6);
		chk(32'(nrst), 32'(r0 + 2));
		for (int i = 0; i < 3; i++)
			wr(ADDR_CAPTURE_PIN_1_CTRL + 12'(4 * i), 32'(CM_OFF));
		kind <= 2'd2;
		repeat (8) @(posedge clk);
		wr(ADDR_CAPTURE_PIN_1_CTRL, 32'(CM_PW_RF));
		wr(ADDR_FLAGS, 32'h7);
		r0 = nrst;
		step(1);
		chk(32'(nrst), 32'(r0 + 1));
		tbase <= 16'h2222;
		step(1);
		rd(ADDR_BUF1, 32'h2222, 32'hFFFF);
		rd(ADDR_FLAGS, 32'h1, 32'h1);
		chk(32'(nrst), 32'(r0 + 1));
		for (int i = 0; i < 2; i++)
		begin
			wr(ADDR_MISC, 32'(i));
			wr(ADDR_CAPTURE_PIN_1_CTRL, 32'(tcode[i]));
			wr(ADDR_FLAGS, 32'h7);
			r0 = nrst;
			r1 = ntrig;
			step(2);
			chk(32'(ntrig), 32'(r1 + 1));
			chk(32'(nrst), 32'(r0 + 1 - i));
			rd(ADDR_FLAGS, 32'h0, 32'h1);
		end
		// first rise captures, then prescaler counts on to its fourth
		wr(ADDR_CAPTURE_PIN_1_CTRL, 32'(CM_RISE4));
		step(2);
		rd(ADDR_FLAGS, 32'h1, 32'h1);
		wr(ADDR_FLAGS, 32'h7);
		tbase <= 16'h4444;
		step(4);
		rd(ADDR_FLAGS, 32'h0, 32'h1);
		step(2);
		rd(ADDR_FLAGS, 32'h1, 32'h1);
		rd(ADDR_BUF1, 32'h4444, 32'hFFFF);
		// four steps keep the phase model where the encoder test expects
		wr(ADDR_CAPTURE_PIN_1_CTRL, 32'(CM_FALL));
		wr(ADDR_FLAGS, 32'h7);
		step(1);
		rd(ADDR_FLAGS, 32'h0, 32'h1);
		step(3);
		rd(ADDR_FLAGS, 32'h1, 32'h1);
		// encoder enabled before pins move; channel 1 mode must be ignored
		wr(ADDR_MISC, 32'h2);
		enc({3'b000, EM_X4_MAT, 2'b00});
		kind <= 2'd1;
		wr(ADDR_BUF3, 32'h5);
		step(1);
		r1 = ntrig;
		wr(ADDR_BUF2, 32'h0);
		wr(ADDR_FLAGS, 32'h7);
		step(3);
		rd(ADDR_BUF2, 32'h3, 32'hFFFF);
		rd(ADDR_ENC_CTRL, 32'h20, 32'h20);
		step(3);
		rd(ADDR_BUF2, 32'h0, 32'hFFFF);
		rd(ADDR_FLAGS, 32'h2, 32'h2);
		rd(ADDR_BUF3, 32'h5, 32'hFFFF);
		chk(32'(ntrig), 32'(r1));
		rev <= 1'b1;
		wr(ADDR_FLAGS, 32'h7);
		step(1);
		rd(ADDR_ENC_CTRL, 32'h0, 32'h20);
		rd(ADDR_FLAGS, 32'h4, 32'h4);
		enc({3'b000, EM_X2_MAT, 2'b00});
		rev <= 1'b0;
		step(1);
		wr(ADDR_BUF2, 32'h0);
		step(4);
		rd(ADDR_BUF2, 32'h2, 32'hFFFF);
		enc({3'b000, EM_X4_IDX, 2'b00});
		rev <= 1'b1;
		step(1);
		wr(ADDR_BUF2, 32'h0);
		step(2);
		rd(ADDR_ENC_CTRL, 32'h40, 32'h40);
		enc({3'b000, EM_X4_IDX, 2'b00});
		rd(ADDR_ENC_CTRL, 32'h0, 32'h40);
		wr(ADDR_FLAGS, 32'h7);
		idx_in <= 1'b1;
		repeat (6) @(posedge clk);
		rd(ADDR_BUF2, 32'h0, 32'hFFFF);
		rd(ADDR_FLAGS, 32'h2, 32'h2);
		idx_in <= 1'b0;
		enc({3'b100, EM_X4_MAT, 2'b00});
		rev <= 1'b0;
		r0 = nvel;
		step(16);
		chk(32'(nvel), 32'(r0));
		enc({3'b000, EM_X4_MAT, 2'b00});
		r0 = nvel;
		step(16);
		p0 = nvel - r0;
		enc({3'b000, EM_X4_MAT, 2'b01});
		r0 = nvel;
		tbase <= 16'h3333;
		step(16);
		r1 = nvel - r0;
		chk(32'(p0), 32'h10);
		chk(32'(r1), 32'h4);
		rd(ADDR_BUF1, 32'h3333, 32'hFFFF);
		tally_and_finish();
	end
endmodule
`default_nettype wire
